/* File: core/sxaf_top.sv */
/*
  address front end of a 14-pin serial port expander: identifier decode,
  command pointer, minimal port bank, input-change interrupt.
  assumes an spi master in mode 0 with a serial clock well below the
  system clock; pins are three-signal (in, out, enable), resolved outside.
*/
//
// Function
// - the device answers to 40h with the strap low and 42h with it high.
// - identifier bits 7..2 must be 010000, bit 1 must equal the strap level.
// - identifier bit 0 set means read, clear means write.
// - port 0 byte bit n maps to port 0 pin n for n 0..7.
// - port 1 byte bits 5..0 map to port 1 pins 5..0, upper two bits unused.
// - after reset all fourteen pins are inputs and none is driven.
// - an active-low reset input reinitialises the whole device.
// - the interrupt output only pulls low and relies on an external pullup.
// - bytes shift in on serial_in and out on serial_out, timed by the clock, framed by select.
// - the interrupt is asserted while any input pin differs from its stored input value.
// - reset clears the pointer to 00h with the step enable at 0.
`timescale 1ns/100ps
module sxaf_top (
  input  wire logic                       i_sys_clk,        // system clock, 250 mhz
  input  wire logic                       i_rst_n,          // reset pin, active low
  input  wire logic                       i_sclk,           // serial clock pin
  input  wire logic                       i_cs_n,           // chip select pin, active low
  input  wire logic                       i_serial_in,      // serial data in pin
  output logic                            o_serial_out,     // serial data out
  output logic                            o_serial_out_oe,  // serial_out drive enable
  input  wire logic                       i_addr_strap,     // identifier strap pin
  input  wire logic [sxaf_pkg::P0_W-1:0]  i_port0_pin,      // port 0 pin levels
  output logic      [sxaf_pkg::P0_W-1:0]  o_port0_pin,      // port 0 drive data
  output logic      [sxaf_pkg::P0_W-1:0]  o_port0_pin_oe,   // port 0 drive enables
  input  wire logic [sxaf_pkg::P1_W-1:0]  i_port1_pin,      // port 1 pin levels
  output logic      [sxaf_pkg::P1_W-1:0]  o_port1_pin,      // port 1 drive data
  output logic      [sxaf_pkg::P1_W-1:0]  o_port1_pin_oe,   // port 1 drive enables
  output logic                            o_int_n,          // interrupt data, always low
  output logic                            o_int_n_oe        // interrupt pull-low enable
);
  import sxaf_pkg::*;

  localparam int unsigned NSYNC = 4 + P0_W + P1_W;

  //////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers for every pin input except the reset pin
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  wire  [NSYNC-1:0] pins_raw = {i_port1_pin, i_port0_pin, i_addr_strap,
                                i_serial_in, i_cs_n, i_sclk};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          sync1_reg[g] <= 1'b0;
          sync2_reg[g] <= 1'b0;
        end else begin
          sync1_reg[g] <= pins_raw[g];
          sync2_reg[g] <= sync1_reg[g];
        end
      end
    end
  endgenerate

  wire            sclk_s  = sync2_reg[0];
  wire            cs_n_s  = sync2_reg[1];
  wire            sin_s   = sync2_reg[2];
  wire            strap_s = sync2_reg[3];
  wire [P0_W-1:0] p0_s    = sync2_reg[4 +: P0_W];
  wire [P1_W-1:0] p1_s    = sync2_reg[4+P0_W +: P1_W];

  //////////////////////////////////////////////////////////////////////////
  sxaf_link_if link ();
  logic sout;

  sxaf_shift u_shift (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_sclk_s  (sclk_s),
    .i_cs_n_s  (cs_n_s),
    .i_sin_s   (sin_s),
    .o_sout    (sout),
    .link      (link)
  );

  //////////////////////////////////////////////////////////////////////////
  // frame decode
  sxaf_state_t      state_reg;
  sxaf_state_t      state_next;
  logic             dir_reg;
  logic [6:0]       ptr_reg;
  logic             step_reg;
  logic [P0_W-1:0]  out0_reg;
  logic [P1_W-1:0]  out1_reg;
  logic [P0_W-1:0]  cfg0_reg;
  logic [P1_W-1:0]  cfg1_reg;
  logic [P0_W-1:0]  in0_reg;
  logic [P1_W-1:0]  in1_reg;
  logic [2:0]       primed_reg;
  logic             oe_reg;
  logic             int_reg;

  wire [7:0] rxb      = link.rx_byte;
  wire       id_match = (rxb[ID_FIX_MSB:ID_FIX_LSB] == ID_FIXED)
                      && (rxb[ID_STRAP_BIT] == strap_s);
  wire       got_id   = link.rx_valid && (state_reg == SXAF_ST_ID);
  wire       got_cmd  = link.rx_valid && (state_reg == SXAF_ST_CMD);
  wire       got_data = link.rx_valid && (state_reg == SXAF_ST_DATA);
  wire       wr_data  = got_data && (dir_reg != DIR_READ);
  wire       rd_data  = got_data && (dir_reg == DIR_READ);
  // step enable walks the whole map; without it the pointer pairs 0/1 of a port group
  wire [6:0] ptr_step = step_reg ? ptr_reg + 7'h01 : {ptr_reg[6:1], ~ptr_reg[0]};

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SXAF_ST_ID:     if (link.rx_valid) state_next = id_match ? SXAF_ST_CMD
                                                                : SXAF_ST_IGNORE;
      SXAF_ST_CMD:    if (link.rx_valid) state_next = SXAF_ST_DATA;
      SXAF_ST_DATA:   state_next = SXAF_ST_DATA;
      SXAF_ST_IGNORE: state_next = SXAF_ST_IGNORE;
      default:        state_next = SXAF_ST_ID;
    endcase
    if (cs_n_s) state_next = SXAF_ST_ID;
  end

  // one strobe per bank register, shared by read selection and writes or input refresh
  wire       hit_in0  = (ptr_reg == REG_IN0);
  wire       hit_in1  = (ptr_reg == REG_IN1);
  wire       hit_out0 = (ptr_reg == REG_OUT0);
  wire       hit_out1 = (ptr_reg == REG_OUT1);
  wire       hit_cfg0 = (ptr_reg == REG_CFG0);
  wire       hit_cfg1 = (ptr_reg == REG_CFG1);

  // read data selection; upper port 1 bits read zero
  wire [7:0] rd_mux =
      hit_in0  ? p0_s :
      hit_in1  ? {2'b00, p1_s} :
      hit_out0 ? out0_reg :
      hit_out1 ? {2'b00, out1_reg} :
      hit_cfg0 ? cfg0_reg :
      hit_cfg1 ? {2'b00, cfg1_reg} : 8'h00;
  assign link.tx_byte = rd_mux;

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= SXAF_ST_ID;
      dir_reg   <= 1'b0;
      ptr_reg   <= PTR_RST;
      step_reg  <= 1'b0;
      oe_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      oe_reg    <= (state_next == SXAF_ST_DATA) && (dir_reg == DIR_READ);
      if (got_id) dir_reg <= rxb[ID_DIR_BIT];
      if (got_cmd) begin
        ptr_reg  <= rxb[6:0];
        step_reg <= rxb[CMD_STEP_BIT];
      end else if (got_data) begin
        ptr_reg  <= ptr_step;
      end
    end
  end

  // synchronisers still hold reset zeros for two edges; sampling the pins
  // any earlier would store zeros and raise a false interrupt after reset
  wire       primed   = primed_reg[2];
  wire       load_in0 = !primed || (rd_data && hit_in0);
  wire       load_in1 = !primed || (rd_data && hit_in1);
  wire       wr_out0  = wr_data && hit_out0;
  wire       wr_out1  = wr_data && hit_out1;
  wire       wr_cfg0  = wr_data && hit_cfg0;
  wire       wr_cfg1  = wr_data && hit_cfg1;

  // port bank
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out0_reg <= OUT0_RST;
      out1_reg <= OUT1_RST;
      cfg0_reg <= CFG0_RST;
      cfg1_reg <= CFG1_RST;
    end else begin
      if (wr_out0) out0_reg <= rxb;
      if (wr_out1) out1_reg <= rxb[P1_W-1:0];
      if (wr_cfg0) cfg0_reg <= rxb;
      if (wr_cfg1) cfg1_reg <= rxb[P1_W-1:0];
    end
  end

  // stored input values; reading an input port refreshes its copy
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      in0_reg    <= '0;
      in1_reg    <= '0;
      primed_reg <= 3'h0;
    end else begin
      primed_reg <= {primed_reg[1:0], 1'b1};
      if (load_in0) in0_reg <= p0_s;
      if (load_in1) in1_reg <= p1_s;
    end
  end

  // only pins configured as inputs can raise the interrupt
  wire [P0_W-1:0] diff0 = (p0_s ^ in0_reg) & cfg0_reg;
  wire [P1_W-1:0] diff1 = (p1_s ^ in1_reg) & cfg1_reg;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) int_reg <= 1'b0;
    else          int_reg <= primed && ((|diff0) || (|diff1));
  end

  //////////////////////////////////////////////////////////////////////////
  assign o_serial_out    = sout;
  assign o_serial_out_oe = oe_reg;
  assign o_port0_pin     = out0_reg;
  assign o_port0_pin_oe  = ~cfg0_reg;
  assign o_port1_pin     = out1_reg;
  assign o_port1_pin_oe  = ~cfg1_reg;
  assign o_int_n         = 1'b0;
  assign o_int_n_oe      = int_reg;
endmodule // sxaf_top

/* File: core/sxaf_pkg.sv */
/*
  constants and types of the serial expander address front end.
  assumes one system clock domain; all serial pins are sampled there.
*/
package sxaf_pkg;
  localparam int unsigned P0_W = 8;                 // port 0 pin count
  localparam int unsigned P1_W = 6;                 // port 1 pin count
  localparam int unsigned SYNC_STAGES = 2;          // flip-flops per pin synchroniser
  // identifier byte layout
  localparam logic [5:0] ID_FIXED    = 6'h10;       // bits 7..2 = 0,1,0,0,0,0
  localparam int unsigned ID_FIX_MSB = 7;
  localparam int unsigned ID_FIX_LSB = 2;
  localparam int unsigned ID_STRAP_BIT = 1;
  localparam int unsigned ID_DIR_BIT   = 0;
  localparam logic        DIR_READ     = 1'b1;
  // command byte layout
  localparam int unsigned CMD_STEP_BIT = 7;
  // register offsets of the small bank behind the pointer
  localparam logic [6:0] REG_IN0  = 7'h00;
  localparam logic [6:0] REG_IN1  = 7'h01;
  localparam logic [6:0] REG_OUT0 = 7'h02;
  localparam logic [6:0] REG_OUT1 = 7'h03;
  localparam logic [6:0] REG_CFG0 = 7'h06;
  localparam logic [6:0] REG_CFG1 = 7'h07;
  // values after reset
  localparam logic [6:0] PTR_RST  = 7'h00;
  localparam logic [7:0] OUT0_RST = 8'hff;
  localparam logic [5:0] OUT1_RST = 6'h3f;
  localparam logic [7:0] CFG0_RST = 8'hff;          // all pins inputs
  localparam logic [5:0] CFG1_RST = 6'h3f;
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef enum logic [1:0] {
    SXAF_ST_ID     = 2'b00,
    SXAF_ST_CMD    = 2'b01,
    SXAF_ST_DATA   = 2'b10,
    SXAF_ST_IGNORE = 2'b11
  } sxaf_state_t;
endpackage

/* File: core/sxaf_link_if.sv */
/*
  byte level link between the serial shifter and the frame decoder.
  assumes both ends run on the system clock.
*/
`timescale 1ns/100ps
interface sxaf_link_if;
  logic [7:0] rx_byte;   // last byte shifted in
  logic       rx_valid;  // one-cycle pulse per byte
  logic [7:0] tx_byte;   // byte to load for shifting out
  modport shifter (output rx_byte, output rx_valid, input tx_byte);
  modport decoder (input rx_byte, input rx_valid, output tx_byte);
endinterface // sxaf_link_if

/* File: core/sxaf_shift.sv */
/*
  serial shifter: samples data on the serial clock rising edge, shifts
  read data out on the falling edge, msb first, framed by chip select.
  assumes inputs already synchronised to i_sys_clk.
*/
`timescale 1ns/100ps
module sxaf_shift (
  input  wire logic       i_sys_clk,   // system clock
  input  wire logic       i_rst_n,     // async reset, active low
  input  wire logic       i_sclk_s,    // synchronised serial clock
  input  wire logic       i_cs_n_s,    // synchronised chip select
  input  wire logic       i_sin_s,     // synchronised serial_in
  output logic            o_sout,      // serial_out data bit
  sxaf_link_if.shifter    link         // byte link
);
  import sxaf_pkg::*;

  logic       sclk_prev_reg;
  logic [2:0] cnt_reg;
  logic [7:0] rx_reg;
  logic [7:0] tx_reg;
  logic [7:0] byte_reg;
  logic       valid_reg;

  wire        rise     = i_sclk_s & ~sclk_prev_reg;
  wire        fall     = ~i_sclk_s & sclk_prev_reg;
  wire  [7:0] rx_next  = {rx_reg[6:0], i_sin_s};
  wire        last_bit = (cnt_reg == BIT_LAST);

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_prev_reg <= 1'b0;
      cnt_reg       <= 3'h0;
      rx_reg        <= 8'h00;
      tx_reg        <= 8'h00;
      byte_reg      <= 8'h00;
      valid_reg     <= 1'b0;
    end else begin
      sclk_prev_reg <= i_sclk_s;
      valid_reg     <= 1'b0;
      if (i_cs_n_s) begin
        cnt_reg <= 3'h0;
        tx_reg  <= link.tx_byte;
      end else if (rise) begin
        rx_reg  <= rx_next;
        cnt_reg <= cnt_reg + 3'h1;
        if (last_bit) begin
          byte_reg  <= rx_next;
          valid_reg <= 1'b1;
        end
      end else if (fall) begin
        // byte boundary: fresh read byte, else next bit
        tx_reg <= (cnt_reg == 3'h0) ? link.tx_byte : {tx_reg[6:0], 1'b0};
      end
    end
  end

  assign link.rx_byte  = byte_reg;
  assign link.rx_valid = valid_reg;
  assign o_sout        = tx_reg[7];
endmodule // sxaf_shift

/* File: sim/sxaf_checker.sv */
/* port assertions for sxaf_top.
   assumes bind below, one system clock domain. */
`timescale 1ns/100ps
module sxaf_checker (
  input wire logic                      i_sys_clk,       // system clock
  input wire logic                      i_rst_n,         // reset, active low
  input wire logic                      i_sclk,          // serial clock
  input wire logic                      i_cs_n,          // chip select
  input wire logic                      o_serial_out,    // serial data out
  input wire logic                      o_serial_out_oe, // serial out enable
  input wire logic [sxaf_pkg::P0_W-1:0] i_port0_pin,     // port 0 levels
  input wire logic [sxaf_pkg::P0_W-1:0] o_port0_pin_oe,  // port 0 enables
  input wire logic [sxaf_pkg::P1_W-1:0] i_port1_pin,     // port 1 levels
  input wire logic [sxaf_pkg::P1_W-1:0] o_port1_pin_oe,  // port 1 enables
  input wire logic                      o_int_n,         // interrupt data
  input wire logic                      o_int_n_oe       // interrupt enable
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  rst_release_a: assert property ($rose(i_rst_n) |-> o_port0_pin_oe == '0
    && o_port1_pin_oe == '0 && !o_serial_out_oe && !o_int_n_oe) else $error("drive after reset");
  int_pull_a: assert property (o_int_n == 1'b0) else $error("interrupt data not low");
  oe_idle_a: assert property (i_cs_n [*8] |-> !o_serial_out_oe)
    else $error("serial out driven outside frame");
  oe_fall_a: assert property ($fell(o_serial_out_oe) |-> $past(i_cs_n, 2))
    else $error("serial out released inside frame");
  oe_rise_a: assert property ($rose(o_serial_out_oe) |-> !i_cs_n && !$past(i_cs_n, 8))
    else $error("serial out enabled without frame");
  data_hold_a: assert property (o_serial_out_oe && i_sclk && $past(i_sclk) &&
    $past(i_sclk, 2) |-> $stable(o_serial_out)) else $error("data moved while clock high");
  dir_idle_a: assert property (i_cs_n [*8] |=> $stable(o_port0_pin_oe)
    && $stable(o_port1_pin_oe)) else $error("pin direction moved without frame");
  int_idle_a: assert property ((i_cs_n && $stable(i_port0_pin) && $stable(i_port1_pin)) [*8]
    |=> $stable(o_int_n_oe)) else $error("interrupt moved with quiet pins");
  cover property ($rose(o_serial_out_oe));
  cover property ($rose(o_int_n_oe));
  cover property ($fell(o_int_n_oe));
endmodule // sxaf_checker
bind sxaf_top sxaf_checker sxaf_checker_i (.i_sys_clk, .i_rst_n, .i_sclk, .i_cs_n,
  .o_serial_out, .o_serial_out_oe, .i_port0_pin, .o_port0_pin_oe, .i_port1_pin,
  .o_port1_pin_oe, .o_int_n, .o_int_n_oe);

/* File: sim/sxaf_master.sv */
/* serial master model, mode 0, msb first, three- or four-byte frames.
   assumes the bench paces it from the system clock. */
`timescale 1ns/100ps
module sxaf_master (
  input  wire logic i_clk,    // system clock, pacing only
  input  wire logic i_sdi,    // device serial_out
  input  wire logic i_sdi_oe, // device serial_out enable
  output logic      o_sclk,   // serial clock, idle low
  output logic      o_cs_n,   // chip select, active low
  output logic      o_sdo     // data to device
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdo  = 1'b1;
  end
  // 16 ns half period gives a 32 ns serial clock
  task automatic half();
    repeat (4) @(negedge i_clk);
  endtask
  // nb bits msb first from tx; rx keeps the last 16 bits, z where undriven
  task automatic frame(input logic [31:0] tx, input int nb, output logic [15:0] rx);
    o_cs_n = 1'b0;
    half();
    for (int i = nb - 1; i >= 0; i--) begin
      o_sdo = tx[i];
      half();
      if (i < 16) rx[i] = i_sdi_oe ? i_sdi : 1'bz;
      o_sclk = 1'b1;
      half();
      o_sclk = 1'b0;
    end
    half();
    o_cs_n = 1'b1;
    o_sdo  = ~o_sdo; // released line keeps no value
    repeat (6) half();
  endtask
  // identifier, then command, then one data byte
  task automatic xfer(input logic [23:0] tx, output logic [7:0] rx);
    logic [15:0] r;
    frame({8'h00, tx}, 24, r);
    rx = r[7:0];
  endtask
endmodule // sxaf_master

/* File: sim/sxaf_top_tb.sv */
/* self-checking bench for sxaf_top with the master model.
   assumes the checker binds itself from its own file. */
`timescale 1ns/100ps
module sxaf_top_tb;
  logic       clk, rst_n, sclk, cs_n, sdi, strap, so, so_oe, int_n, int_oe;
  logic [7:0] p0_in, p0_out, p0_oe, p0_ext, rd;
  logic [5:0] p1_in, p1_out, p1_oe, p1_ext;
  logic [15:0] rd2;
  int         n_mismatch = 0;
  int         tests_run  = 0;
  int         cycles     = 0;
  // pins resolved from device enables and the outside drivers
  assign p0_in = (p0_oe & p0_out) | (~p0_oe & p0_ext);
  assign p1_in = (p1_oe & p1_out) | (~p1_oe & p1_ext);
  sxaf_top sxaf_top_i (.i_sys_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_serial_in(sdi), .o_serial_out(so), .o_serial_out_oe(so_oe), .i_addr_strap(strap),
    .i_port0_pin(p0_in), .o_port0_pin(p0_out), .o_port0_pin_oe(p0_oe), .i_port1_pin(p1_in),
    .o_port1_pin(p1_out), .o_port1_pin_oe(p1_oe), .o_int_n(int_n), .o_int_n_oe(int_oe));
  sxaf_master sxaf_master_i (.i_clk(clk), .i_sdi(so), .i_sdi_oe(so_oe), .o_sclk(sclk),
    .o_cs_n(cs_n), .o_sdo(sdi));
  //////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // hang limit, far above the fourteen frames run here
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("port0 oe", 8'h00, p0_oe);
    chk("port1 oe", 8'h00, {2'h0, p1_oe});
    chk("port0 out", 8'hff, p0_out);
    chk("int pins", 8'h00, {6'h0, int_oe, int_n});
  endtask
  task automatic t_read();
    @(negedge clk);
    p0_ext = 8'ha5;
    p1_ext = 6'h2c;
    for (int k = 0; k < 20 && int_oe !== 1'b1; k++) @(negedge clk);
    chk("int raised", 8'h01, {7'h0, int_oe});
    sxaf_master_i.xfer({8'h41, 8'h00, 8'h00}, rd);
    chk("input 0", 8'ha5, rd);
    sxaf_master_i.xfer({8'h41, 8'h01, 8'h00}, rd);
    chk("input 1", 8'h2c, rd);
    chk("int cleared", 8'h00, {7'h0, int_oe});
  endtask
  task automatic t_strap();
    @(negedge clk) strap = 1'b1;
    repeat (8) @(negedge clk);
    sxaf_master_i.xfer({8'h43, 8'h00, 8'h00}, rd);
    chk("id 43h", 8'ha5, rd);
    sxaf_master_i.xfer({8'h41, 8'h00, 8'h00}, rd);
    chk("id 41h strap high", 8'hzz, rd);
    sxaf_master_i.xfer({8'hc3, 8'h00, 8'h00}, rd);
    chk("id c3h", 8'hzz, rd);
    @(negedge clk) strap = 1'b0;
    repeat (8) @(negedge clk);
  endtask
  task automatic t_write();
    sxaf_master_i.xfer({8'h40, 8'h02, 8'h5a}, rd);
    chk("write frame drive", 8'hzz, rd);
    sxaf_master_i.xfer({8'h40, 8'h06, 8'h0f}, rd);
    chk("port0 out", 8'h5a, p0_out);
    chk("port0 oe", 8'hf0, p0_oe);
    sxaf_master_i.xfer({8'h41, 8'h00, 8'h00}, rd);
    chk("mixed input 0", 8'h55, rd);
    sxaf_master_i.xfer({8'h40, 8'h03, 8'hd5}, rd);
    chk("port1 out", 8'h15, {2'h0, p1_out});
    sxaf_master_i.frame({8'h41, 8'h81, 8'h00, 8'h00}, 32, rd2);
    chk("step read in1", 8'h2c, rd2[15:8]);
    chk("step read out0", 8'h5a, rd2[7:0]);
    sxaf_master_i.frame({8'h41, 8'h01, 8'h00, 8'h00}, 32, rd2);
    chk("pair read in1", 8'h2c, rd2[15:8]);
    chk("pair read in0", 8'h55, rd2[7:0]);
    sxaf_master_i.xfer({8'h42, 8'h02, 8'h00}, rd);
    chk("foreign id write", 8'h5a, p0_out);
    sxaf_master_i.xfer({8'h40, 8'h07, 8'h3c}, rd);
    chk("port1 oe", 8'h03, {2'h0, p1_oe});
  endtask
  task automatic t_rerst();
    @(negedge clk) rst_n = 1'b0;
    repeat (8) @(negedge clk);
    chk("port0 oe in reset", 8'h00, p0_oe);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("port0 out after reset", 8'hff, p0_out);
    chk("int after reset", 8'h00, {7'h0, int_oe});
    chk("port1 oe after reset", 8'h00, {2'h0, p1_oe});
    sxaf_master_i.xfer({8'h41, 8'h00, 8'h00}, rd);
    chk("input 0 after reset", 8'ha5, rd);
  endtask
  initial begin
    rst_n  = 1'b0;
    strap  = 1'b0;
    p0_ext = 8'h00;
    p1_ext = 6'h00;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_read();
    t_strap();
    t_write();
    t_rerst();
    test_done();
  end
endmodule // sxaf_top_tb
